// [logic/pic_pkg.sv]
package pic_pkg;

  // ------------------------------------------------------------
  // Bank port map (device side, 4-bit port address)
  // ------------------------------------------------------------
  localparam logic [3:0] PORT_CMD      = 4'h0;
  localparam logic [3:0] PORT_DATA     = 4'h1;
  localparam logic [3:0] PORT_COMPAT   = 4'h2;
  localparam int         PORT_VEC_BIT  = 3;

  // ------------------------------------------------------------
  // Command word fields
  // ------------------------------------------------------------
  localparam int SEL_IC4_BIT    = 0;
  localparam int SEL_SINGLE_BIT = 1;
  localparam int SEL_LTIM_BIT   = 3;
  localparam int SEL_ID_BIT     = 4;
  localparam int MODE_AEOI_BIT  = 1;
  localparam int MODE_SFNM_BIT  = 4;
  localparam int EOIW_ROT_BIT   = 7;
  localparam int EOIW_SL_BIT    = 6;
  localparam int EOIW_EOI_BIT   = 5;
  localparam int RPC_ESMM_BIT   = 6;
  localparam int RPC_SMM_BIT    = 5;
  localparam int RPC_ID_BIT     = 3;
  localparam int RPC_POLL_BIT   = 2;
  localparam int RPC_RR_BIT     = 1;
  localparam int RPC_RIS_BIT    = 0;
  localparam int POLL_HIT_BIT   = 7;

  // ------------------------------------------------------------
  // Values after reset or after the first init word
  // ------------------------------------------------------------
  localparam logic [2:0] LOW_PRIO_RST = 3'h7;
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [7:0] EDGE_ARM     = 8'hFF;

  // ------------------------------------------------------------
  // Controller APB registers
  // ------------------------------------------------------------
  localparam logic [7:0] APB_CMD_OFS    = 8'h00;
  localparam logic [7:0] APB_RESULT_OFS = 8'h04;
  localparam int CMD_ADDR_LSB   = 8;
  localparam int CMD_OP_LSB     = 12;
  localparam int RES_CAS_BIT    = 8;
  localparam int RES_BUSY_BIT   = 16;
  localparam int RES_INTR_BIT   = 17;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ  = 2'b01,
    OP_ACK   = 2'b10
  } io_op_t;

endpackage : pic_pkg

// [logic/pic_io_if.sv]
interface pic_io_if;
  logic       wr;
  logic       rd;
  logic       ack;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       cascade;
  logic       intr;

  modport device (
    input  wr, rd, ack, addr, wdata,
    output rdata, rvalid, cascade, intr
  );
  modport host (
    output wr, rd, ack, addr, wdata,
    input  rdata, rvalid, cascade, intr
  );
endinterface : pic_io_if

// [logic/prio_pick.sv]
module prio_pick #(
  parameter int N = 8
) (
  input  wire logic [N-1:0]         vec,
  input  wire logic [$clog2(N)-1:0] low,
  output logic                      found,
  output logic [$clog2(N)-1:0]      level
);
  localparam int LW = $clog2(N);

  initial begin
    if (N < 2 || (1 << LW) != N) begin
      $error("prio_pick: N must be a power of two");
    end
  end

  // Walk from lowest rank up so the highest priority overwrites last
  always_comb begin
    logic [LW-1:0] idx;
    idx   = '0;
    found = 1'b0;
    level = '0;
    for (int k = N; k >= 1; k--) begin
      idx = LW'(low + LW'(k));
      if (vec[idx]) begin
        found = 1'b1;
        level = idx;
      end
    end
  end
endmodule : prio_pick

// [logic/pic_bank.sv]
// Register access over APB and the address map were left to the implementer.
module pic_bank (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] irq_n,
  output logic            compat_req,
  pic_io_if.device        io
);

  typedef enum logic [2:0] {
    ST_UNINIT  = 3'b000,
    ST_COMPAT  = 3'b001,
    ST_CASCADE = 3'b010,
    ST_MODE    = 3'b011,
    ST_RUN     = 3'b100
  } init_state_t;

  function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] low);
    return 3'(lvl - low - 3'h1);
  endfunction : rank

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  init_state_t state_r;
  logic [7:0]  irq_meta_r;
  logic [7:0]  irq_sync_r;
  logic [7:0]  prev_r;
  logic [7:0]  irr_r;
  logic [7:0]  isr_r;
  logic [7:0]  imr_r;
  logic [7:0]  cascade_r;
  logic [7:0]  compat_r;
  logic [7:0]  vec_r [8];
  logic [2:0]  low_r;
  logic        ltim_r;
  logic        single_r;
  logic        want_mode_r;
  logic        aeoi_r;
  logic        sfnm_r;
  logic        rot_aeoi_r;
  logic        smm_r;
  logic        read_isr_r;
  logic        poll_r;
  logic        compat_req_r;

  logic [7:0]  req;
  logic [7:0]  irr_nxt;
  logic [7:0]  isr_nxt;
  logic        cmd_wr;
  logic        data_wr;
  logic        sel_wr;
  logic        eoiw_wr;
  logic        rpc_wr;
  logic        mask_wr;
  logic        poll_rd;
  logic        serve;
  logic        grant;
  logic        r_found;
  logic [2:0]  r_lvl;
  logic        s_found;
  logic [2:0]  s_lvl;
  logic [2:0]  eoi_lvl;
  logic        eoi_do;
  logic        running;

  assign compat_req = compat_req_r;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign running = (state_r == ST_RUN);
  assign req     = ~irq_sync_r;
  assign cmd_wr  = io.wr && (io.addr == pic_pkg::PORT_CMD);
  assign data_wr = io.wr && (io.addr == pic_pkg::PORT_DATA);
  assign sel_wr  = cmd_wr && io.wdata[pic_pkg::SEL_ID_BIT];
  assign eoiw_wr = cmd_wr && running && !io.wdata[pic_pkg::SEL_ID_BIT]
                   && !io.wdata[pic_pkg::RPC_ID_BIT];
  assign rpc_wr  = cmd_wr && running && !io.wdata[pic_pkg::SEL_ID_BIT]
                   && io.wdata[pic_pkg::RPC_ID_BIT];
  assign mask_wr = data_wr && running;
  assign poll_rd = io.rd && (io.addr == pic_pkg::PORT_CMD) && poll_r;
  assign serve   = io.ack || poll_rd;

  // ------------------------------------------------------------
  // Priority resolution
  // ------------------------------------------------------------
  prio_pick #(.N(8)) u_req_pick (
    .vec   (irr_r & ~imr_r),
    .low   (low_r),
    .found (r_found),
    .level (r_lvl)
  );

  // Special mask mode lets masked in-service levels stop blocking
  prio_pick #(.N(8)) u_isr_pick (
    .vec   (smm_r ? (isr_r & ~imr_r) : isr_r),
    .low   (low_r),
    .found (s_found),
    .level (s_lvl)
  );

  assign grant = running && r_found &&
                 (!s_found || (rank(r_lvl, low_r) < rank(s_lvl, low_r)) ||
                  (sfnm_r && (r_lvl == s_lvl) && cascade_r[r_lvl]));

  assign eoi_lvl = io.wdata[pic_pkg::EOIW_SL_BIT] ? io.wdata[2:0] : s_lvl;
  assign eoi_do  = eoiw_wr && io.wdata[pic_pkg::EOIW_EOI_BIT] &&
                   (io.wdata[pic_pkg::EOIW_SL_BIT] || s_found);

  // ------------------------------------------------------------
  // Request pins: two-stage synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_meta_r <= 8'hFF;
      irq_sync_r <= 8'hFF;
    end else begin
      irq_meta_r <= irq_n;
      irq_sync_r <= irq_meta_r;
    end
  end

  // ------------------------------------------------------------
  // Initialization sequence
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= ST_UNINIT;
      ltim_r      <= 1'b0;
      single_r    <= 1'b1;
      want_mode_r <= 1'b0;
      cascade_r   <= pic_pkg::BYTE_RST;
      compat_r    <= pic_pkg::BYTE_RST;
      aeoi_r      <= 1'b0;
      sfnm_r      <= 1'b0;
    end else if (sel_wr) begin
      state_r     <= ST_COMPAT;
      ltim_r      <= io.wdata[pic_pkg::SEL_LTIM_BIT];
      single_r    <= io.wdata[pic_pkg::SEL_SINGLE_BIT];
      want_mode_r <= io.wdata[pic_pkg::SEL_IC4_BIT];
      aeoi_r      <= 1'b0;
      sfnm_r      <= 1'b0;
    end else if (data_wr) begin
      case (state_r)
        ST_COMPAT: begin
          compat_r <= io.wdata;
          if (!single_r) begin
            state_r <= ST_CASCADE;
          end else begin
            state_r <= want_mode_r ? ST_MODE : ST_RUN;
          end
        end
        ST_CASCADE: begin
          cascade_r <= io.wdata;
          state_r   <= want_mode_r ? ST_MODE : ST_RUN;
        end
        ST_MODE: begin
          aeoi_r  <= io.wdata[pic_pkg::MODE_AEOI_BIT];
          sfnm_r  <= io.wdata[pic_pkg::MODE_SFNM_BIT];
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end
  end

  // Set wins over the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compat_req_r <= 1'b0;
    end else if (data_wr && (state_r == ST_COMPAT)) begin
      compat_req_r <= 1'b1;
    end else if (io.rd && (io.addr == pic_pkg::PORT_COMPAT)) begin
      compat_req_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Request and in-service registers
  // ------------------------------------------------------------
  always_comb begin
    irr_nxt = ltim_r ? req : ((irr_r | (req & ~prev_r)) & req);
    if (serve && grant) begin
      irr_nxt[r_lvl] = 1'b0;
    end
    if (sel_wr) begin
      irr_nxt = pic_pkg::BYTE_RST;
    end
  end

  always_comb begin
    isr_nxt = isr_r;
    if (serve && grant && !aeoi_r) begin
      isr_nxt[r_lvl] = 1'b1;
    end
    if (eoi_do) begin
      isr_nxt[eoi_lvl] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= pic_pkg::EDGE_ARM;
      irr_r  <= pic_pkg::BYTE_RST;
      isr_r  <= pic_pkg::BYTE_RST;
    end else begin
      prev_r <= sel_wr ? pic_pkg::EDGE_ARM : req;
      irr_r  <= irr_nxt;
      isr_r  <= isr_nxt;
    end
  end

  // ------------------------------------------------------------
  // Mask and priority rotation
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imr_r <= pic_pkg::BYTE_RST;
    end else if (sel_wr) begin
      imr_r <= pic_pkg::BYTE_RST;
    end else if (mask_wr) begin
      imr_r <= io.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_r      <= pic_pkg::LOW_PRIO_RST;
      rot_aeoi_r <= 1'b0;
    end else if (sel_wr) begin
      low_r      <= pic_pkg::LOW_PRIO_RST;
      rot_aeoi_r <= 1'b0;
    end else if (eoiw_wr) begin
      if (eoi_do && io.wdata[pic_pkg::EOIW_ROT_BIT]) begin
        low_r <= eoi_lvl;
      end else if (!io.wdata[pic_pkg::EOIW_EOI_BIT]) begin
        if (io.wdata[pic_pkg::EOIW_SL_BIT]) begin
          if (io.wdata[pic_pkg::EOIW_ROT_BIT]) begin
            low_r <= io.wdata[2:0];
          end
        end else begin
          rot_aeoi_r <= io.wdata[pic_pkg::EOIW_ROT_BIT];
        end
      end
    end else if (serve && grant && aeoi_r && rot_aeoi_r) begin
      low_r <= r_lvl;
    end
  end

  // ------------------------------------------------------------
  // Read selection, poll and special mask
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smm_r      <= 1'b0;
      read_isr_r <= 1'b0;
      poll_r     <= 1'b0;
    end else if (sel_wr) begin
      smm_r      <= 1'b0;
      read_isr_r <= 1'b0;
      poll_r     <= 1'b0;
    end else if (rpc_wr) begin
      if (io.wdata[pic_pkg::RPC_ESMM_BIT]) begin
        smm_r <= io.wdata[pic_pkg::RPC_SMM_BIT];
      end
      if (io.wdata[pic_pkg::RPC_POLL_BIT]) begin
        poll_r <= 1'b1;
      end else if (io.wdata[pic_pkg::RPC_RR_BIT]) begin
        read_isr_r <= io.wdata[pic_pkg::RPC_RIS_BIT];
      end
    end else if (poll_rd) begin
      poll_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Vector registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        vec_r[i] <= pic_pkg::BYTE_RST;
      end
    end else if (io.wr && io.addr[pic_pkg::PORT_VEC_BIT]) begin
      vec_r[io.addr[2:0]] <= io.wdata;
    end
  end

  // ------------------------------------------------------------
  // Answers: one cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io.rdata   <= pic_pkg::BYTE_RST;
      io.rvalid  <= 1'b0;
      io.cascade <= 1'b0;
    end else begin
      io.rvalid  <= io.rd || io.ack;
      io.cascade <= io.ack && grant && !single_r && cascade_r[r_lvl];
      if (io.ack) begin
        // No request granted: answer with the level 7 vector
        io.rdata <= grant ? vec_r[r_lvl] : vec_r[7];
      end else if (io.rd) begin
        if (io.addr[pic_pkg::PORT_VEC_BIT]) begin
          io.rdata <= vec_r[io.addr[2:0]];
        end else begin
          case (io.addr)
            pic_pkg::PORT_CMD: begin
              if (poll_r) begin
                io.rdata <= {grant, 4'h0, r_lvl};
              end else begin
                io.rdata <= read_isr_r ? isr_r : irr_r;
              end
            end
            pic_pkg::PORT_DATA:   io.rdata <= imr_r;
            pic_pkg::PORT_COMPAT: io.rdata <= compat_r;
            default:              io.rdata <= pic_pkg::BYTE_RST;
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io.intr <= 1'b0;
    end else begin
      io.intr <= grant;
    end
  end

endmodule : pic_bank

// [logic/pic_host.sv]
module pic_host #(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  pic_io_if.host                 io
);

  initial begin
    if (ADDR_W < 3 || ADDR_W > 8) begin
      $error("pic_host: ADDR_W must be 3..8");
    end
  end

  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [13:0] cmd_r;
  logic [7:0]  result_r;
  logic        cas_r;
  logic        busy_r;
  logic        mapped;
  logic        take;
  logic [7:0]  addr8;
  pic_pkg::io_op_t op;

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign addr8   = 8'(paddr);
  assign mapped  = (addr8 == pic_pkg::APB_CMD_OFS) || (addr8 == pic_pkg::APB_RESULT_OFS);
  assign take    = psel && penable && pready_r && pwrite && !busy_r
                   && (addr8 == pic_pkg::APB_CMD_OFS);
  assign op      = pic_pkg::io_op_t'(pwdata[pic_pkg::CMD_OP_LSB +: 2]);

  // ------------------------------------------------------------
  // APB slave: zero-wait answer in the access cycle
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        if (addr8 == pic_pkg::APB_CMD_OFS) begin
          prdata_r <= {18'h0_0000, cmd_r};
        end else if (addr8 == pic_pkg::APB_RESULT_OFS) begin
          prdata_r <= {14'h0000, io.intr, busy_r, 7'h00, cas_r, result_r};
        end else begin
          prdata_r <= 32'h0000_0000;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Port strobes: one cycle, then reads and acknowledges wait for the answer
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io.wr    <= 1'b0;
      io.rd    <= 1'b0;
      io.ack   <= 1'b0;
      io.addr  <= 4'h0;
      io.wdata <= 8'h00;
      cmd_r    <= 14'h0000;
      busy_r   <= 1'b0;
    end else begin
      io.wr  <= take && (op == pic_pkg::OP_WRITE);
      io.rd  <= take && (op == pic_pkg::OP_READ);
      io.ack <= take && (op == pic_pkg::OP_ACK);
      if (take) begin
        cmd_r    <= pwdata[13:0];
        io.addr  <= pwdata[pic_pkg::CMD_ADDR_LSB +: 4];
        io.wdata <= pwdata[7:0];
        busy_r   <= (op == pic_pkg::OP_READ) || (op == pic_pkg::OP_ACK);
      end else if (io.rvalid) begin
        busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= 8'h00;
      cas_r    <= 1'b0;
    end else if (io.rvalid) begin
      result_r <= io.rdata;
      cas_r    <= io.cascade;
    end
  end

endmodule : pic_host

// [dv/pic_io_checker.sv]
module pic_io_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic       ack,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       cascade,
  input wire logic       intr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic       run_r;
  logic       ever_r;
  logic       first_r;
  logic       poll_r;
  logic [1:0] left_r;
  logic [3:0] rsel_r;
  logic [7:0] mask_r;
  logic [7:0] compat_r;
  logic [7:0] vec_r [8];
  wire logic  cmd_w = wr && addr == pic_pkg::PORT_CMD;
  wire logic  sel_w = cmd_w && wdata[pic_pkg::SEL_ID_BIT];
  wire logic  dat_w = wr && addr == pic_pkg::PORT_DATA;
  wire logic  pol_w = run_r && cmd_w && !wdata[pic_pkg::SEL_ID_BIT] && wdata[3] && wdata[2];

  // ----
  // Init sequence mirror
  // ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r  <= 2'h0;
      run_r   <= 1'b0;
      first_r <= 1'b0;
    end else if (sel_w) begin
      // Owed: compat, cascade unless single, mode if asked
      left_r  <= 2'(1 + !wdata[pic_pkg::SEL_SINGLE_BIT] + wdata[pic_pkg::SEL_IC4_BIT]);
      run_r   <= 1'b0;
      first_r <= 1'b1;
    end else if (dat_w && left_r != 2'h0) begin
      left_r  <= left_r - 2'h1;
      run_r   <= left_r == 2'h1;
      first_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r   <= pic_pkg::BYTE_RST;
      compat_r <= pic_pkg::BYTE_RST;
      ever_r   <= 1'b0;
      poll_r   <= 1'b0;
      rsel_r   <= 4'h0;
      vec_r    <= '{default: 8'h00};
    end else begin
      ever_r   <= ever_r || run_r;
      mask_r   <= sel_w ? pic_pkg::BYTE_RST : (dat_w && run_r) ? wdata : mask_r;
      compat_r <= (dat_w && first_r) ? wdata : compat_r;
      poll_r   <= pol_w || (poll_r && !sel_w && !(rd && addr == pic_pkg::PORT_CMD));
      rsel_r   <= rd ? addr : rsel_r;
      if (wr && addr[pic_pkg::PORT_VEC_BIT]) begin
        vec_r[addr[2:0]] <= wdata;
      end
    end
  end

  // ----
  // Properties
  // ----
  sequence poll_issue;
    poll_r && rd && addr == pic_pkg::PORT_CMD;
  endsequence
  sequence poll_answer;
    rvalid && rdata[6:3] == 4'h0;
  endsequence

  answer_time_a: assert property (
    (rd || ack) |=> rvalid) else $error("no answer after read");
  answer_cause_a: assert property (
    rvalid |-> $past(rd) || $past(ack)) else $error("answer without request");
  cascade_ack_a: assert property (
    cascade |-> rvalid && $past(ack)) else $error("cascade outside acknowledge");
  rdata_hold_a: assert property (
    !rvalid |-> $stable(rdata)) else $error("read data moved");
  mask_read_a: assert property (
    rd && addr == pic_pkg::PORT_DATA |=> rdata == mask_r) else $error("mask readback");
  compat_read_a: assert property (
    rd && addr == pic_pkg::PORT_COMPAT |=> rdata == compat_r) else $error("compat readback");
  vector_read_a: assert property (
    rvalid && $past(rd) && rsel_r[3] |-> rdata == vec_r[rsel_r[2:0]]) else $error("vector");
  poll_code_a: assert property (
    poll_issue |=> poll_answer) else $error("poll code format");
  idle_intr_a: assert property (
    !(ever_r || run_r) |-> !intr) else $error("request before init");
endmodule : pic_io_checker

// [dv/pic_bank_command_programming_tb_top.sv]
module pic_bank_command_programming_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] P_CMD = pic_pkg::PORT_CMD;
  localparam logic [3:0] P_DAT = pic_pkg::PORT_DATA;
  localparam logic [3:0] P_CPT = pic_pkg::PORT_COMPAT;
  logic        pclk;
  logic        presetn;
  logic [7:0]  irq_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        compat_req;
  logic [31:0] r;
  logic        e;
  int          failures;
  int          samples_checked;

  pic_io_if io_if ();
  pic_bank pic_bank_i (.pclk(pclk), .presetn(presetn), .irq_n(irq_n),
    .compat_req(compat_req), .io(io_if.device));
  pic_host pic_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io(io_if.host));
  pic_io_checker pic_io_checker_i (.pclk(pclk), .presetn(presetn), .wr(io_if.wr),
    .rd(io_if.rd), .ack(io_if.ack), .addr(io_if.addr), .wdata(io_if.wdata),
    .rdata(io_if.rdata), .rvalid(io_if.rvalid), .cascade(io_if.cascade), .intr(io_if.intr));

  // ----
  // Bus tasks
  // ----
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    samples_checked++;
    if (got !== x) begin
      $display("[ERR] %s expected %h seen %h", nm, x, got);
      failures++;
    end
  endtask : chk

  // Idle edge first, so release and next setup never share a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      report_and_stop();
    end
  endtask : apb

  task automatic io(input pic_pkg::io_op_t op, input logic [3:0] pt, input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, pic_pkg::APB_CMD_OFS, {18'h0, op, pt, d});
    do begin
      apb(1'b0, pic_pkg::APB_RESULT_OFS, 32'h0);
      n++;
    end while (r[pic_pkg::RES_BUSY_BIT] !== 1'b0 && n < 20);
    if (r[pic_pkg::RES_BUSY_BIT] !== 1'b0) begin
      failures++;
      report_and_stop();
    end
  endtask : io

  task automatic rdc(input string nm, input logic [3:0] pt, input logic [7:0] x);
    io(pic_pkg::OP_READ, pt, 8'h00);
    chk(nm, {24'h0, x}, {24'h0, r[7:0]});
  endtask : rdc

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ----
  // Main sequence
  // ----
  initial begin
    presetn = 1'b0;
    irq_n = 8'hFF;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pic_pkg::APB_RESULT_OFS, 32'h0);
    chk("result", 32'h0, r);
    apb(1'b0, 8'h08, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    for (int i = 0; i < 8; i++) begin
      io(pic_pkg::OP_WRITE, 4'(8 + i), 8'(8'h40 + i));
    end
    for (int i = 0; i < 8; i++) begin
      rdc("vector", 4'(8 + i), 8'(8'h40 + i));
    end
    io(pic_pkg::OP_WRITE, P_DAT, 8'hFF);
    rdc("mask pre-init", P_DAT, 8'h00);
    rdc("unused port", 4'h3, 8'h00);
    io(pic_pkg::OP_WRITE, P_CMD, 8'h11);
    io(pic_pkg::OP_WRITE, P_DAT, 8'h3C);
    chk("compat_req", 32'h1, {31'h0, compat_req});
    io(pic_pkg::OP_WRITE, P_DAT, 8'h04);
    io(pic_pkg::OP_WRITE, P_DAT, 8'h00);
    rdc("compat", P_CPT, 8'h3C);
    chk("compat_req", 32'h0, {31'h0, compat_req});
    io(pic_pkg::OP_WRITE, P_DAT, 8'hF0);
    rdc("mask", P_DAT, 8'hF0);
    irq_n <= 8'hFB;
    io(pic_pkg::OP_WRITE, P_CMD, 8'h0A);
    rdc("request", P_CMD, 8'h04);
    chk("intr", 32'h1, {31'h0, r[pic_pkg::RES_INTR_BIT]});
    io(pic_pkg::OP_ACK, P_CMD, 8'h00);
    chk("ack", 32'h142, {23'h0, r[8:0]});
    io(pic_pkg::OP_WRITE, P_CMD, 8'h0B);
    rdc("in service", P_CMD, 8'h04);
    rdc("in service", P_CMD, 8'h04);
    io(pic_pkg::OP_WRITE, P_CMD, 8'h20);
    rdc("after eoi", P_CMD, 8'h00);
    irq_n <= 8'hFF;
    rdc("mask", P_DAT, 8'hF0);
    irq_n <= 8'hFD;
    io(pic_pkg::OP_WRITE, P_CMD, 8'h0C);
    rdc("poll", P_CMD, 8'h81);
    rdc("poll service", P_CMD, 8'h02);
    io(pic_pkg::OP_WRITE, P_CMD, 8'h68);
    io(pic_pkg::OP_WRITE, P_CMD, 8'h1A);
    io(pic_pkg::OP_WRITE, P_DAT, 8'h00);
    rdc("mask cleared", P_DAT, 8'h00);
    rdc("request sel", P_CMD, 8'h02);
    io(pic_pkg::OP_WRITE, P_DAT, 8'h55);
    rdc("mask", P_DAT, 8'h55);
    rdc("compat", P_CPT, 8'h00);
    chk("compat_req", 32'h0, {31'h0, compat_req});
    // Level 1 still in service from the poll: rotate-on-specific clears it
    io(pic_pkg::OP_WRITE, P_CMD, 8'hE1);
    io(pic_pkg::OP_WRITE, P_CMD, 8'h0B);
    rdc("specific eoi", P_CMD, 8'h00);
    io(pic_pkg::OP_WRITE, P_CMD, 8'h0C);
    rdc("poll rotated", P_CMD, 8'h81);
    rdc("poll in service", P_CMD, 8'h02);
    report_and_stop();
  end
endmodule : pic_bank_command_programming_tb_top
